// >>> shared/tm8_pkg.sv
// Package for the 8-bit timer/counter with two waveform outputs.
// Assumes an APB master with 32-bit data and word-aligned registers.
package tm8_pkg;

    // Register indices; byte address is four times the index
    localparam logic [7:0] IDX_CTRL_A = 8'h1B;
    localparam logic [7:0] IDX_CTRL_B = 8'h1A;
    localparam logic [7:0] IDX_COUNT = 8'h19;
    localparam logic [7:0] IDX_CMP_A = 8'h18;
    localparam logic [7:0] IDX_CMP_B = 8'h17;
    localparam logic [7:0] IDX_FLAGS = 8'h1C;

    // Reset values
    localparam logic [7:0] RST_CTRL_A = 8'h00;
    localparam logic [7:0] RST_CTRL_B = 8'h00;
    localparam logic [7:0] RST_BYTE = 8'h00;

    // Counter limits
    localparam logic [7:0] CNT_MAX = 8'hFF;
    localparam logic [7:0] CNT_BOTTOM = 8'h00;

    // Flag bit positions in the flag register
    localparam int FLG_MATCH_A = 0;
    localparam int FLG_OVF = 1;
    localparam int FLG_MATCH_B = 2;

    // Waveform modes
    localparam logic [2:0] MODE_NORMAL = 3'h0;
    localparam logic [2:0] MODE_PC_FF = 3'h1;
    localparam logic [2:0] MODE_CTC = 3'h2;
    localparam logic [2:0] MODE_FAST_FF = 3'h3;
    localparam logic [2:0] MODE_PC_CMP = 3'h5;
    localparam logic [2:0] MODE_FAST_CMP = 3'h7;

    // Prescaler masks: tick when the masked bits are all ones
    localparam logic [9:0] PS_MASK_8 = 10'h007;
    localparam logic [9:0] PS_MASK_64 = 10'h03F;
    localparam logic [9:0] PS_MASK_256 = 10'h0FF;
    localparam logic [9:0] PS_MASK_1024 = 10'h3FF;

    // Control register A fields
    typedef struct packed {
        logic [1:0] chan_a_out_mode;
        logic [1:0] chan_b_out_mode;
        logic [1:0] rsv;
        logic [1:0] wave_mode_sel;
    } tm8_ctrl_a_s;

    // Control register B fields
    typedef struct packed {
        logic [3:0] rsv;
        logic wave_mode_hi;
        logic [2:0] clock_select;
    } tm8_ctrl_b_s;

    typedef enum logic [2:0] {
        RS_NONE = 3'h0, RS_CTRL_A = 3'h1, RS_CTRL_B = 3'h3,
        RS_COUNT = 3'h2, RS_CMP_A = 3'h6, RS_CMP_B = 3'h7,
        RS_FLAGS = 3'h5
    } tm8_sel_e;

    typedef enum logic {DIR_UP = 1'b0, DIR_DOWN = 1'b1} tm8_dir_e;

endpackage : tm8_pkg

// >>> hw/tm8_timer8.sv
// 8-bit timer/counter with waveform output control, APB slave.
// Assumes a 100 MHz pclk, pins synchronous to pclk, port pin logic
// outside that merges the pin output and enable.
`timescale 1ns/1ps

module tm8_timer8
    import tm8_pkg::*;
#(
    parameter int ADDR_W = 8
)
(
    // APB slave
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // External count source
    input wire logic ext_clk_pin,
    // Port logic of the two pins
    input wire logic [1:0] port_dir,
    input wire logic [1:0] port_data,
    // Pin drive, index 0 is channel A
    output logic [1:0] pin_out,
    output logic [1:0] pin_oe
);

    // Address decode shared by read and write paths
    function automatic tm8_sel_e reg_sel(input logic [ADDR_W-1:0] a);
        logic [7:0] idx;
        idx = 8'(a[ADDR_W-1:2]);
        reg_sel = RS_NONE;
        if (a[1:0] == 2'h0)
        begin
            case (idx)
                IDX_CTRL_A: reg_sel = RS_CTRL_A;
                IDX_CTRL_B: reg_sel = RS_CTRL_B;
                IDX_COUNT: reg_sel = RS_COUNT;
                IDX_CMP_A: reg_sel = RS_CMP_A;
                IDX_CMP_B: reg_sel = RS_CMP_B;
                IDX_FLAGS: reg_sel = RS_FLAGS;
                default: reg_sel = RS_NONE;
            endcase
        end
    endfunction : reg_sel

    // Next compare output for one channel
    function automatic logic oc_next(
        input logic cur,
        input logic [1:0] com,
        input logic is_a,
        input logic hi,
        input logic fast,
        input logic pc,
        input logic match,
        input logic at_bot,
        input logic at_top,
        input logic up,
        input logic cmp_top
    );
        logic m;
        m = match & ~(cmp_top & com[1]);
        oc_next = cur;
        if (!fast && !pc)
        begin
            if (match)
            begin
                case (com)
                    2'h1: oc_next = ~cur;
                    2'h2: oc_next = 1'b0;
                    2'h3: oc_next = 1'b1;
                    default: oc_next = cur;
                endcase
            end
        end
        else if (com == 2'h1)
        begin
            if (is_a && hi && match)
                oc_next = ~cur;
        end
        else if (fast)
        begin
            if (m)
                oc_next = com[0];
            if (at_bot && com[1])
                oc_next = ~com[0];
        end
        else
        begin
            if (m)
                oc_next = up ? com[0] : ~com[0];
            if (at_top && cmp_top && com[1])
                oc_next = ~com[0];
        end
    endfunction : oc_next

    tm8_ctrl_a_s ctrl_a_q;
    tm8_ctrl_b_s ctrl_b_q;
    logic [7:0] cnt_q;
    logic [7:0] cmp_buf_q [2];
    logic [7:0] cmp_q [2];
    logic [2:0] flags_q;
    tm8_dir_e dir_q;
    logic blk_q;
    logic [9:0] ps_q;
    logic ext_q;
    logic [1:0] oc_q;
    logic [1:0] pin_out_q;
    logic [1:0] pin_oe_q;
    logic [31:0] prdata_q;
    logic pready_q;
    logic pslverr_q;

    tm8_sel_e sel;
    logic wr_acc;
    logic [2:0] mode;
    logic is_fast;
    logic is_pc;
    logic [7:0] top;
    logic tick;
    logic cnt_wr;
    logic wrap;
    logic pc_top;
    logic pc_bot;
    logic ovf_ev;
    logic [1:0] match;
    logic [1:0] com [2];

    // Bus decode and mode decode
    assign sel = reg_sel(paddr);
    assign wr_acc = psel & penable & pready_q & pwrite;
    assign cnt_wr = wr_acc & (sel == RS_COUNT);
    assign mode = {ctrl_b_q.wave_mode_hi, ctrl_a_q.wave_mode_sel};
    assign is_fast = (mode == MODE_FAST_FF) | (mode == MODE_FAST_CMP);
    assign is_pc = (mode == MODE_PC_FF) | (mode == MODE_PC_CMP);
    assign com[0] = ctrl_a_q.chan_a_out_mode;
    assign com[1] = ctrl_a_q.chan_b_out_mode;

    // TOP selection; reserved modes count like normal
    always_comb
    begin
        case (mode)
            MODE_CTC, MODE_FAST_CMP, MODE_PC_CMP: top = cmp_q[0];
            default: top = CNT_MAX;
        endcase
    end

    // Timer tick selection, used as clock enable
    always_comb
    begin
        case (ctrl_b_q.clock_select)
            3'h1: tick = 1'b1;
            3'h2: tick = (ps_q & PS_MASK_8) == PS_MASK_8;
            3'h3: tick = (ps_q & PS_MASK_64) == PS_MASK_64;
            3'h4: tick = (ps_q & PS_MASK_256) == PS_MASK_256;
            3'h5: tick = ps_q == PS_MASK_1024;
            3'h6: tick = ext_q & ~ext_clk_pin;
            3'h7: tick = ~ext_q & ext_clk_pin;
            default: tick = 1'b0;
        endcase
    end

    // Counting events
    assign wrap = tick & ~is_pc & (cnt_q == top);
    assign pc_top = tick & is_pc & (dir_q == DIR_UP) & (cnt_q == top);
    assign pc_bot = tick & is_pc & (dir_q == DIR_DOWN)
        & (cnt_q == CNT_BOTTOM);
    assign match[0] = tick & ~blk_q & (cnt_q == cmp_q[0]);
    assign match[1] = tick & ~blk_q & (cnt_q == cmp_q[1]);

    // Overflow event per mode
    always_comb
    begin
        if (is_pc)
            ovf_ev = pc_bot;
        else if (mode == MODE_FAST_CMP)
            ovf_ev = wrap;
        else
            ovf_ev = tick & (cnt_q == CNT_MAX);
    end

    // Prescaler and external pin history
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ps_q <= 10'h000;
            ext_q <= 1'b0;
        end
        else
        begin
            ps_q <= ps_q + 10'h001;
            ext_q <= ext_clk_pin;
        end
    end

    // Counter, all on pclk with tick as enable
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            cnt_q <= CNT_BOTTOM;
        else if (cnt_wr)
            cnt_q <= pwdata[7:0];
        else if (tick)
        begin
            if (is_pc)
            begin
                if (dir_q == DIR_UP)
                    cnt_q <= (cnt_q == top) ? cnt_q - 8'h01
                        : cnt_q + 8'h01;
                else
                    cnt_q <= (cnt_q == CNT_BOTTOM) ? cnt_q + 8'h01
                        : cnt_q - 8'h01;
            end
            else if (wrap)
                cnt_q <= CNT_BOTTOM;
            else
                cnt_q <= cnt_q + 8'h01;
        end
    end

    // Count direction for dual-slope counting
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            dir_q <= DIR_UP;
        else if (!is_pc)
            dir_q <= DIR_UP;
        else if (pc_top)
            dir_q <= DIR_DOWN;
        else if (pc_bot)
            dir_q <= DIR_UP;
    end

    // A counter write blocks the match on the next tick
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            blk_q <= 1'b0;
        else if (cnt_wr)
            blk_q <= 1'b1;
        else if (tick)
            blk_q <= 1'b0;
    end

    // Control registers; reserved bits forced to zero
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl_a_q <= RST_CTRL_A;
            ctrl_b_q <= RST_CTRL_B;
        end
        else if (wr_acc)
        begin
            if (sel == RS_CTRL_A)
                ctrl_a_q <= {pwdata[7:4], 2'b00, pwdata[1:0]};
            if (sel == RS_CTRL_B)
                ctrl_b_q <= {4'h0, pwdata[3:0]};
        end
    end

    // Per-channel compare and output logic
    for (genvar ch = 0; ch < 2; ch++)
    begin : g_chan
        localparam tm8_sel_e SEL_CMP = (ch == 0) ? RS_CMP_A : RS_CMP_B;
        logic wr_cmp;
        logic load_ev;
        logic pin_conn;
        assign wr_cmp = wr_acc & (sel == SEL_CMP);
        assign load_ev = is_fast ? wrap : pc_top;
        // A's toggle setting stays off the pin in PWM unless mode hi is set
        assign pin_conn = (com[ch] != 2'h0) && !((ch == 0)
            && (is_fast || is_pc) && (com[ch] == 2'h1)
            && !ctrl_b_q.wave_mode_hi);

        // Buffer as written by software
        always_ff @(posedge pclk or negedge presetn)
        begin
            if (!presetn)
                cmp_buf_q[ch] <= RST_BYTE;
            else if (wr_cmp)
                cmp_buf_q[ch] <= pwdata[7:0];
        end

        // Active compare value
        always_ff @(posedge pclk or negedge presetn)
        begin
            if (!presetn)
                cmp_q[ch] <= RST_BYTE;
            else if (!is_fast && !is_pc)
                cmp_q[ch] <= wr_cmp ? pwdata[7:0] : cmp_buf_q[ch];
            else if (load_ev)
                cmp_q[ch] <= cmp_buf_q[ch];
        end

        // Compare output register
        always_ff @(posedge pclk or negedge presetn)
        begin
            if (!presetn)
                oc_q[ch] <= 1'b0;
            else
                oc_q[ch] <= oc_next(oc_q[ch], com[ch], ch == 0,
                    ctrl_b_q.wave_mode_hi, is_fast, is_pc, match[ch],
                    wrap, pc_top, dir_q == DIR_UP, cmp_q[ch] == top);
        end

        // Pin override and direction gating
        always_ff @(posedge pclk or negedge presetn)
        begin
            if (!presetn)
            begin
                pin_out_q[ch] <= 1'b0;
                pin_oe_q[ch] <= 1'b0;
            end
            else
            begin
                pin_out_q[ch] <= pin_conn ? oc_q[ch]
                    : port_data[ch];
                pin_oe_q[ch] <= port_dir[ch];
            end
        end
    end

    // Sticky flags; write one clears, a new event wins
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            flags_q <= 3'h0;
        else
        begin
            logic [2:0] clr;
            logic [2:0] set;
            clr = (wr_acc && sel == RS_FLAGS) ? pwdata[2:0] : 3'h0;
            set = 3'h0;
            set[FLG_MATCH_A] = match[0];
            set[FLG_MATCH_B] = match[1];
            set[FLG_OVF] = ovf_ev;
            flags_q <= set | (flags_q & ~clr);
        end
    end

    // APB answer: data latched in setup, ready in the access cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata_q <= 32'h0000_0000;
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
        end
        else
        begin
            pready_q <= psel & ~penable;
            pslverr_q <= psel & ~penable & (sel == RS_NONE);
            if (psel && !penable)
            begin
                case (sel)
                    RS_CTRL_A: prdata_q <= {24'h0, ctrl_a_q};
                    RS_CTRL_B: prdata_q <= {24'h0, ctrl_b_q};
                    RS_COUNT: prdata_q <= {24'h0, cnt_q};
                    RS_CMP_A: prdata_q <= {24'h0, cmp_buf_q[0]};
                    RS_CMP_B: prdata_q <= {24'h0, cmp_buf_q[1]};
                    RS_FLAGS: prdata_q <= {29'h0, flags_q};
                    default: prdata_q <= 32'h0000_0000;
                endcase
            end
        end
    end

    // Outputs straight from flip-flops
    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign pin_out = pin_out_q;
    assign pin_oe = pin_oe_q;

    // Checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_ctc_match;
        mode == MODE_CTC && tick && !cnt_wr && !blk_q
            && cnt_q == cmp_q[0];
    endsequence
    sequence s_cleared_flagged;
        cnt_q == CNT_BOTTOM && flags_q[FLG_MATCH_A];
    endsequence

    property p_ctc_clear;
        s_ctc_match |=> s_cleared_flagged;
    endproperty
    a_ctc_clear: assert property (p_ctc_clear)
        else $error("clear-on-match did not clear and flag");

    property p_rsv_read;
        psel && !penable && sel == RS_CTRL_A |=> prdata_q[3:2] == 2'h0;
    endproperty
    a_rsv_read: assert property (p_rsv_read)
        else $error("reserved control bits read nonzero");

    property p_pin_port;
        com[0] == 2'h0 |=> pin_out_q[0] == $past(port_data[0]);
    endproperty
    a_pin_port: assert property (p_pin_port)
        else $error("disconnected pin A not on port data");

    property p_norm_clr;
        !is_fast && !is_pc && com[0] == 2'h2 && match[0]
            |=> oc_q[0] == 1'b0 ##1 pin_out_q[0] == 1'b0;
    endproperty
    a_norm_clr: assert property (p_norm_clr)
        else $error("non-PWM clear on match failed");

    property p_fast_bot;
        is_fast && com[0] == 2'h2 && wrap |=> oc_q[0] == 1'b1;
    endproperty
    a_fast_bot: assert property (p_fast_bot)
        else $error("fast PWM output not set at BOTTOM");

    property p_pc_up;
        is_pc && com[1] == 2'h2 && match[1] && dir_q == DIR_UP
            && cmp_q[1] != top |=> oc_q[1] == 1'b0;
    endproperty
    a_pc_up: assert property (p_pc_up)
        else $error("phase PWM up-count match did not clear B");

    property p_b_reserved;
        is_fast && com[1] == 2'h1 && $stable(com[1])
            |=> $stable(oc_q[1]);
    endproperty
    a_b_reserved: assert property (p_b_reserved)
        else $error("reserved B mode changed the output");

    property p_norm_ovf;
        mode == MODE_NORMAL && tick && !cnt_wr && cnt_q == CNT_MAX
            |=> cnt_q == CNT_BOTTOM && flags_q[FLG_OVF];
    endproperty
    a_norm_ovf: assert property (p_norm_ovf)
        else $error("normal mode overflow not seen at MAX");

    property p_stop;
        ctrl_b_q.clock_select == 3'h0 && !cnt_wr |=> $stable(cnt_q);
    endproperty
    a_stop: assert property (p_stop)
        else $error("counter moved while stopped");

    property p_ctrl_wr;
        wr_acc && sel == RS_CTRL_A
            |=> ctrl_a_q.wave_mode_sel == $past(pwdata[1:0]);
    endproperty
    a_ctrl_wr: assert property (p_ctrl_wr)
        else $error("control write not taken on next edge");

endmodule : tm8_timer8

// >>> verification/tm8_timer8_tb.sv
// Self-checking bench for the 8-bit timer with two waveform outputs.
// Assumes the APB slave answers with pready; the timer is stepped by
// rising edges on ext_clk_pin with clock_select 7.
`timescale 1ns/1ps

module tm8_timer8_tb
    import tm8_pkg::*;
;
    localparam int TIMEOUT = 20000;
    // APB and pin stimulus
    logic pclk;
    logic presetn;
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
    logic ext_clk_pin;
    logic [1:0] port_dir;
    logic [1:0] port_data;
    // Design outputs
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [1:0] pin_out;
    logic [1:0] pin_oe;
    int n_errors = 0;
    int n_compared = 0;
    int cyc = 0;
    logic [31:0] rd;
    logic er;
    logic p0;

    tm8_timer8 #(.ADDR_W(8)) u_tm8_timer8 (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .ext_clk_pin(ext_clk_pin),
        .port_dir(port_dir), .port_data(port_data), .pin_out(pin_out),
        .pin_oe(pin_oe)
    );

    // Clock
    initial
    begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    // Cycle limit against a hung handshake
    always @(posedge pclk)
    begin
        cyc <= cyc + 1;
        if (cyc == TIMEOUT)
        begin
            n_errors++;
            $display("[FAIL] cycle_limit exp done got hang");
            summarize();
        end
    end

    task automatic summarize();
        $display("compared %0d mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : summarize

    // One APB transfer: setup, access, wait for pready
    task automatic apb(input logic wr, input logic [7:0] idx,
                       input logic [31:0] wd, output logic [31:0] rdat,
                       output logic err);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= {idx[5:0], 2'b00};
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        rdat = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [7:0] idx, input logic [31:0] d);
        logic [31:0] x;
        logic e;
        apb(1'b1, idx, d, x, e);
    endtask : wr

    task automatic chk32(input string nm, input logic [31:0] e,
                         input logic [31:0] g);
        n_compared++;
        if (g !== e)
        begin
            n_errors++;
            $display("[FAIL] %s exp %h got %h", nm, e, g);
        end
    endtask : chk32

    task automatic chk2(input string nm, input logic [1:0] e,
                        input logic [1:0] g);
        n_compared++;
        if (g !== e)
        begin
            n_errors++;
            $display("[FAIL] %s exp %b got %b", nm, e, g);
        end
    endtask : chk2

    task automatic rd_chk(input string nm, input logic [7:0] idx,
                          input logic [31:0] e);
        logic [31:0] x;
        logic s;
        apb(1'b0, idx, 32'h0, x, s);
        chk32(nm, e, x);
    endtask : rd_chk

    // Timer steps: one rising edge on the external pin per step
    task automatic tick(input int n);
        repeat (n)
        begin
            @(posedge pclk);
            ext_clk_pin <= 1'b1;
            @(posedge pclk);
            ext_clk_pin <= 1'b0;
            repeat (2) @(posedge pclk);
        end
    endtask : tick

    // Stop, load compares in normal mode, zero count, clear flags, start
    task automatic setup(input logic [31:0] a, input logic hi,
                         input logic [31:0] ca, input logic [31:0] cb);
        wr(IDX_CTRL_B, 32'h0);
        wr(IDX_CTRL_A, 32'h0);
        wr(IDX_CMP_A, ca);
        wr(IDX_CMP_B, cb);
        wr(IDX_COUNT, 32'h0);
        wr(IDX_FLAGS, 32'h07);
        wr(IDX_CTRL_A, a);
        wr(IDX_CTRL_B, {28'h0, hi, 3'h7});
    endtask : setup

    // Main sequence
    initial
    begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        ext_clk_pin = 1'b0;
        port_dir = 2'b00;
        port_data = 2'b00;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;

        rd_chk("ctrl_reg_a", IDX_CTRL_A, 32'h0);
        rd_chk("ctrl_reg_b", IDX_CTRL_B, 32'h0);
        rd_chk("count_value", IDX_COUNT, 32'h0);
        rd_chk("compare_value_a", IDX_CMP_A, 32'h0);
        rd_chk("compare_value_b", IDX_CMP_B, 32'h0);
        rd_chk("flags", IDX_FLAGS, 32'h0);
        $display("test reset_values done");

        wr(IDX_CTRL_A, 32'hFF);
        rd_chk("ctrl_reg_a", IDX_CTRL_A, 32'hF3);
        wr(IDX_CTRL_B, 32'hFF);
        rd_chk("ctrl_reg_b", IDX_CTRL_B, 32'h0F);
        wr(IDX_CTRL_B, 32'h0);
        wr(IDX_CTRL_A, 32'h0);
        apb(1'b0, 8'h03, 32'h0, rd, er);
        chk32("unmapped_data", 32'h0, rd);
        chk32("unmapped_err", 32'h1, {31'h0, er});
        $display("test register_access done");

        // Disconnected outputs pass port data and direction through
        port_dir <= 2'b10;
        port_data <= 2'b01;
        repeat (3) @(posedge pclk);
        chk2("pin_oe", 2'b10, pin_oe);
        chk2("pin_out", 2'b01, pin_out);
        port_dir <= 2'b11;
        wr(IDX_CTRL_A, 32'h43);
        port_data <= 2'b00;
        repeat (3) @(posedge pclk);
        chk2("pin_out", 2'b00, pin_out);
        port_data <= 2'b01;
        repeat (3) @(posedge pclk);
        chk2("pin_out", 2'b01, pin_out);
        port_data <= 2'b00;
        $display("test pin_passthrough done");

        // Clear on match: A toggles, B sets, counter wraps at compare A
        setup(32'h72, 1'b0, 32'h3, 32'h1);
        p0 = pin_out[0];
        tick(6);
        chk2("pin_out", {1'b1, ~p0}, pin_out);
        rd_chk("count_value", IDX_COUNT, 32'h2);
        rd_chk("flags", IDX_FLAGS, 32'h05);
        $display("test clear_on_match done");

        // Normal mode overflow at MAX
        setup(32'h00, 1'b0, 32'h3, 32'h1);
        wr(IDX_COUNT, 32'hFE);
        tick(2);
        rd_chk("count_value", IDX_COUNT, 32'h0);
        rd_chk("flags", IDX_FLAGS, 32'h02);
        $display("test normal_overflow done");

        // Fast PWM, non-inverting and inverting, both channels
        for (int m = 2; m <= 3; m++)
        begin
            logic [1:0] mm;
            mm = m[1:0];
            setup({24'h0, mm, mm, 4'h3}, 1'b0, 32'h3, 32'h3);
            tick(256);
            chk2("pin_out", {2{mm == 2'h2}}, pin_out);
            tick(4);
            chk2("pin_out", {2{mm == 2'h3}}, pin_out);
        end
        $display("test fast_pwm done");

        // Non-PWM clear on A and toggle on B, then reserved B in fast PWM
        setup(32'h90, 1'b0, 32'h2, 32'h2);
        tick(3);
        chk2("pin_out", 2'b00, pin_out);
        wr(IDX_CTRL_A, 32'h93);
        tick(1);
        chk2("pin_out", 2'b00, pin_out);
        $display("test clear_and_reserved done");

        // Fast PWM with compare A as TOP and toggle on A
        setup(32'h43, 1'b1, 32'h3, 32'h3);
        // Let the pin follow the compare output once mode hi is set
        repeat (2) @(posedge pclk);
        p0 = pin_out[0];
        tick(4);
        chk2("pin_out_a", {1'b0, ~p0}, {1'b0, pin_out[0]});
        tick(2);
        rd_chk("count_value", IDX_COUNT, 32'h2);
        rd_chk("flags", IDX_FLAGS, 32'h07);
        $display("test fast_pwm_top done");

        // Phase correct PWM, up match and down match, both channels
        for (int m = 2; m <= 3; m++)
        begin
            logic [1:0] mm;
            mm = m[1:0];
            setup({24'h0, mm, mm, 4'h1}, 1'b0, 32'h3, 32'h3);
            tick(100);
            chk2("pin_out", {2{mm == 2'h3}}, pin_out);
            tick(410);
            chk2("pin_out", {2{mm == 2'h2}}, pin_out);
        end
        $display("test phase_pwm done");
        summarize();
    end
endmodule : tm8_timer8_tb
